//--- core/physical_region_access_guard.sv
`timescale 1ns/1ns
module physical_region_access_guard #(
    parameter int NUM_ENTRIES = 16,
    parameter int GRAIN = 0,
    parameter int PHYS_W = 34
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic machineWidth64,
    input wire logic csrValid,
    input wire logic csrWrite,
    input wire logic csrSel,
    input wire logic [5:0] csrNum,
    input wire logic [1:0] csrPriv,
    input wire logic [63:0] csrWdata,
    output logic csrDone,
    output logic csrIllegal,
    output logic [63:0] csrRdata,
    input wire logic chkValid,
    input wire logic [55:0] chkAddr,
    input wire logic [1:0] chkSize,
    input wire logic [1:0] chkType,
    input wire logic [1:0] chkPriv,
    input wire logic chkPageWalk,
    input wire logic modifyPrivilege,
    input wire logic [1:0] previousPrivilege,
    output logic chkDone,
    output logic chkFault,
    output logic faultInstr,
    output logic faultLoad,
    output logic faultStore
);
    // ----------------------------------------
    // sizing
    // ----------------------------------------
    // arrays keep one slot even with no entries so that elaboration stays legal
    localparam int NE = (NUM_ENTRIES == 0) ? 1 : NUM_ENTRIES;
    localparam int AW = PHYS_W - 2;
    localparam logic [53:0] IMPL_MASK = (54'h1 << AW) - 54'h1;
    localparam logic [53:0] ZERO_MASK = (GRAIN >= 1) ? ((54'h1 << GRAIN) - 54'h1) : 54'h0;
    localparam logic [53:0] ONE_MASK = (GRAIN >= 2) ? ((54'h1 << (GRAIN - 1)) - 54'h1) : 54'h0;
    localparam logic HAS_ENTRIES = (NUM_ENTRIES > 0);

    logic [7:0] cfgQ [NE];
    logic [53:0] addrQ [NE];

    // ----------------------------------------
    // register access decode
    // ----------------------------------------
    logic csrBad;
    logic csrWe;

    always_comb begin
        csrBad = (csrPriv != prag_pkg::PRIV_MACHINE);
        if (csrSel == prag_pkg::CSR_SEL_CFG) begin
            if (csrNum >= 6'(prag_pkg::CFG_REG_COUNT)) begin
                csrBad = 1'b1;
            end
            if (machineWidth64 && csrNum[0]) begin
                csrBad = 1'b1;
            end
        end
        csrWe = csrValid && csrWrite && !csrBad;
    end

    // ----------------------------------------
    // entry storage, one slice per entry
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NE; gi++) begin : gEntry
            logic cfgHit;
            logic addrHit;
            logic lockedHere;
            logic nextGuards;
            logic [7:0] laneByte;
            logic [7:0] legal;
            logic [53:0] addrNew;

            always_comb begin
                lockedHere = cfgQ[gi][prag_pkg::CFG_BIT_LOCK];
                // a locked top-of-range entry also guards the base it borrows
                nextGuards = 1'b0;
                if (gi + 1 < NUM_ENTRIES) begin
                    nextGuards = cfgQ[(gi + 1) % NE][prag_pkg::CFG_BIT_LOCK]
                        && (cfgQ[(gi + 1) % NE][prag_pkg::CFG_MODE_HI:prag_pkg::CFG_MODE_LO]
                        == prag_pkg::MODE_TOP_OF_RANGE);
                end
                // register number times four is the first entry of both layouts
                cfgHit = (gi < NUM_ENTRIES) && (csrSel == prag_pkg::CSR_SEL_CFG)
                    && (machineWidth64 ? (csrNum[3:1] == 3'(gi / 8))
                    : (csrNum[3:0] == 4'(gi / 4)));
                laneByte = machineWidth64 ? csrWdata[8 * (gi % 8) +: 8]
                    : csrWdata[8 * (gi % 4) +: 8];
                legal = laneByte & prag_pkg::CFG_WRITABLE;
                if (!legal[prag_pkg::CFG_BIT_READ] && legal[prag_pkg::CFG_BIT_WRITE]) begin
                    legal[prag_pkg::CFG_BIT_WRITE] = 1'b0;
                end
                if ((GRAIN >= 1) && (legal[prag_pkg::CFG_MODE_HI:prag_pkg::CFG_MODE_LO]
                        == prag_pkg::MODE_ALIGNED_FOUR_BYTE)) begin
                    legal[prag_pkg::CFG_MODE_HI:prag_pkg::CFG_MODE_LO] = prag_pkg::MODE_OFF;
                end
                addrHit = (gi < NUM_ENTRIES) && (csrSel == prag_pkg::CSR_SEL_ADDR)
                    && (csrNum == 6'(gi));
                addrNew = machineWidth64 ? csrWdata[53:0] : {22'h0, csrWdata[31:0]};
                addrNew = addrNew & IMPL_MASK;
            end

            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    cfgQ[gi] <= prag_pkg::CFG_RESET;
                end else if (ce && csrWe && cfgHit && !lockedHere) begin
                    cfgQ[gi] <= legal;
                end
            end

            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    addrQ[gi] <= prag_pkg::ADDR_RESET;
                end else if (ce && csrWe && addrHit && !lockedHere && !nextGuards) begin
                    addrQ[gi] <= addrNew;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // register read-back
    // ----------------------------------------
    logic [63:0] readValue;

    always_comb begin
        int idx;
        logic [53:0] view;
        idx = 0;
        view = 54'h0;
        readValue = 64'h0;
        if (csrSel == prag_pkg::CSR_SEL_CFG) begin
            for (int k = 0; k < 8; k++) begin
                idx = 4 * int'(csrNum[3:0]) + k;
                if ((idx < NUM_ENTRIES) && (machineWidth64 || k < 4)) begin
                    readValue[8 * k +: 8] = cfgQ[idx % NE];
                end
            end
        end else if (int'(csrNum) < NUM_ENTRIES) begin
            idx = int'(csrNum);
            view = addrQ[idx % NE];
            // the view changes with the mode, the stored bits do not
            if (cfgQ[idx % NE][prag_pkg::CFG_MODE_HI]) begin
                view = view | ONE_MASK;
            end else begin
                view = view & ~ZERO_MASK;
            end
            readValue = {10'h0, view};
            if (!machineWidth64) begin
                readValue[63:32] = 32'h0;
            end
        end
    end

    // ----------------------------------------
    // register access answer
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            csrDone <= 1'b0;
        end else if (ce) begin
            csrDone <= csrValid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            csrIllegal <= 1'b0;
        end else if (ce) begin
            csrIllegal <= csrValid && csrBad;
        end
    end

    // a refused access returns zero so nothing leaks below machine mode
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            csrRdata <= 64'h0;
        end else if (ce) begin
            csrRdata <= (csrValid && !csrBad) ? readValue : 64'h0;
        end
    end

    // ----------------------------------------
    // access check
    // ----------------------------------------
    logic [1:0] effPriv;
    logic isMachine;
    logic [56:0] accLo;
    logic [56:0] accHi;
    logic [NE-1:0] hitVec;
    logic [NE-1:0] passVec;
    logic found;
    logic granted;
    logic fail;

    always_comb begin
        if (chkPageWalk) begin
            effPriv = prag_pkg::PRIV_SUPER;
        end else if ((chkType != prag_pkg::ACC_FETCH) && modifyPrivilege) begin
            effPriv = previousPrivilege;
            // a reserved previous privilege never counts as machine
        end else begin
            effPriv = chkPriv;
        end
        isMachine = (effPriv == prag_pkg::PRIV_MACHINE);
        // the access is zero-extended before any comparison
        accLo = {1'b0, chkAddr};
        accHi = accLo + ((57'h1 << chkSize) - 57'h1);
    end

    generate
        for (gi = 0; gi < NE; gi++) begin : gMatch
            logic anyHit;
            logic allHit;
            logic permBit;

            prag_entry_match #(
                .GRAIN(GRAIN)
            ) uMatch (
                .mode(cfgQ[gi][prag_pkg::CFG_MODE_HI:prag_pkg::CFG_MODE_LO]),
                .addrOwn(addrQ[gi]),
                .addrPrev((gi == 0) ? 54'h0 : addrQ[(gi + NE - 1) % NE]),
                .accLo(accLo),
                .accHi(accHi),
                .anyHit(anyHit),
                .allHit(allHit)
            );

            always_comb begin
                case (chkType)
                    prag_pkg::ACC_FETCH: permBit = cfgQ[gi][prag_pkg::CFG_BIT_EXEC];
                    prag_pkg::ACC_LOAD: permBit = cfgQ[gi][prag_pkg::CFG_BIT_READ];
                    default: permBit = cfgQ[gi][prag_pkg::CFG_BIT_WRITE];
                endcase
            end

            always_comb begin
                hitVec[gi] = (gi < NUM_ENTRIES) && anyHit;
                // partial cover fails whatever the lock and permission bits say
                passVec[gi] = allHit && ((isMachine && !cfgQ[gi][prag_pkg::CFG_BIT_LOCK])
                    || permBit);
            end
        end
    endgenerate

    prag_priority #(
        .N(NE)
    ) uPriority (
        .hit(hitVec),
        .pass(passVec),
        .found(found),
        .granted(granted)
    );

    always_comb begin
        if (found) begin
            fail = !granted;
        end else begin
            fail = !isMachine && HAS_ENTRIES;
        end
    end

    // ----------------------------------------
    // access check answer
    // ----------------------------------------
    // the result belongs to the access presented one edge earlier
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            chkDone <= 1'b0;
        end else if (ce) begin
            chkDone <= chkValid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            chkFault <= 1'b0;
        end else if (ce) begin
            chkFault <= chkValid && fail;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            faultInstr <= 1'b0;
        end else if (ce) begin
            faultInstr <= chkValid && fail && (chkType == prag_pkg::ACC_FETCH);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            faultLoad <= 1'b0;
        end else if (ce) begin
            faultLoad <= chkValid && fail && (chkType == prag_pkg::ACC_LOAD);
        end
    end

    // type 3 is reserved and is handled as a store
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            faultStore <= 1'b0;
        end else if (ce) begin
            faultStore <= chkValid && fail
                && (chkType != prag_pkg::ACC_FETCH) && (chkType != prag_pkg::ACC_LOAD);
        end
    end

endmodule : physical_region_access_guard

//--- core/prag_pkg.sv
package prag_pkg;

    // ----------------------------------------
    // configuration byte fields
    // ----------------------------------------
    localparam int CFG_BIT_READ = 0;
    localparam int CFG_BIT_WRITE = 1;
    localparam int CFG_BIT_EXEC = 2;
    localparam int CFG_MODE_LO = 3;
    localparam int CFG_MODE_HI = 4;
    localparam int CFG_BIT_LOCK = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // bits 6:5 are reserved and read as zero
    localparam logic [7:0] CFG_WRITABLE = 8'h9f;

    // ----------------------------------------
    // matching modes
    // ----------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TOP_OF_RANGE = 2'h1;
    localparam logic [1:0] MODE_ALIGNED_FOUR_BYTE = 2'h2;
    localparam logic [1:0] MODE_ALIGNED_POWER_OF_TWO = 2'h3;

    // ----------------------------------------
    // privilege levels and access kinds
    // ----------------------------------------
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;
    localparam logic [1:0] ACC_FETCH = 2'h0;
    localparam logic [1:0] ACC_LOAD = 2'h1;
    localparam logic [1:0] ACC_STORE = 2'h2;

    // ----------------------------------------
    // widths, counts and register numbering
    // ----------------------------------------
    localparam int MAX_ENTRIES = 64;
    localparam int CFG_REG_COUNT = 16;
    localparam int ADDR_REG_W = 54;
    localparam int PHYS_W_MAX = 56;
    localparam int BYTE_CMP_W = 57;
    localparam int DATA_W = 64;
    localparam int NARROW_W = 32;
    localparam logic [53:0] ADDR_RESET = 54'h0;
    localparam logic CSR_SEL_CFG = 1'b0;
    localparam logic CSR_SEL_ADDR = 1'b1;

endpackage : prag_pkg

//--- core/prag_entry_match.sv
`timescale 1ns/1ns
module prag_entry_match #(
    parameter int GRAIN = 0
) (
    input wire logic [1:0] mode,
    input wire logic [53:0] addrOwn,
    input wire logic [53:0] addrPrev,
    input wire logic [56:0] accLo,
    input wire logic [56:0] accHi,
    output logic anyHit,
    output logic allHit
);
    // ----------------------------------------
    // grain masks on the word address
    // ----------------------------------------
    localparam logic [53:0] ZERO_MASK = (GRAIN >= 1) ? ((54'h1 << GRAIN) - 54'h1) : 54'h0;
    localparam logic [53:0] ONE_MASK = (GRAIN >= 2) ? ((54'h1 << (GRAIN - 1)) - 54'h1) : 54'h0;

    logic [53:0] torTop;
    logic [53:0] torBot;
    logic [53:0] napVal;
    logic [53:0] napVar;
    logic [53:0] loW;
    logic [53:0] hiW;
    logic empty;
    logic [56:0] loB;
    logic [56:0] hiB;

    always_comb begin
        torTop = addrOwn & ~ZERO_MASK;
        torBot = addrPrev & ~ZERO_MASK;
        napVal = addrOwn | ONE_MASK;
        // trailing ones plus the bit above them vary inside the region
        napVar = (mode == prag_pkg::MODE_ALIGNED_FOUR_BYTE) ? 54'h0
            : (napVal ^ (napVal + 54'h1));
        empty = 1'b0;
        loW = 54'h0;
        hiW = 54'h0;
        case (mode)
            prag_pkg::MODE_TOP_OF_RANGE: begin
                empty = (torBot >= torTop);
                loW = torBot;
                hiW = torTop - 54'h1;
            end
            prag_pkg::MODE_ALIGNED_FOUR_BYTE,
            prag_pkg::MODE_ALIGNED_POWER_OF_TWO: begin
                loW = napVal & ~napVar;
                hiW = napVal | napVar;
            end
            default: begin
                empty = 1'b1;
            end
        endcase
        loB = {1'b0, loW, 2'b00};
        hiB = {1'b0, hiW, 2'b11};
        anyHit = !empty && (accLo <= hiB) && (accHi >= loB);
        allHit = anyHit && (accLo >= loB) && (accHi <= hiB);
    end

endmodule : prag_entry_match

//--- core/prag_priority.sv
`timescale 1ns/1ns
module prag_priority #(
    parameter int N = 16
) (
    input wire logic [N-1:0] hit,
    input wire logic [N-1:0] pass,
    output logic found,
    output logic granted
);
    // ----------------------------------------
    // lowest-numbered hit wins
    // ----------------------------------------
    always_comb begin
        found = 1'b0;
        granted = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                found = 1'b1;
                granted = pass[i];
            end
        end
    end

endmodule : prag_priority

//--- testbench/prag_asserts.sv
`timescale 1ns/1ns
module prag_asserts #(
    parameter int PHYS_W = 34
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic machineWidth64,
    input wire logic csrValid,
    input wire logic csrWrite,
    input wire logic csrSel,
    input wire logic [5:0] csrNum,
    input wire logic [1:0] csrPriv,
    input wire logic [63:0] csrWdata,
    input wire logic csrDone,
    input wire logic csrIllegal,
    input wire logic [63:0] csrRdata,
    input wire logic chkValid,
    input wire logic [1:0] chkType,
    input wire logic chkDone,
    input wire logic chkFault,
    input wire logic faultInstr,
    input wire logic faultLoad,
    input wire logic faultStore
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // multi-step behaviour
    // ----------------------------------------
    sequence s_rw_write;
        csrValid && ce && csrWrite && !csrSel && csrNum == 6'h00 && csrPriv == 2'h3
            && csrWdata[1:0] == 2'h2;
    endsequence
    sequence s_cfg0_read;
        csrValid && ce && !csrWrite && !csrSel && csrNum == 6'h00 && csrPriv == 2'h3;
    endsequence
    property p_rw_kept;
        s_rw_write ##1 s_cfg0_read |=> csrRdata[1:0] != 2'h2;
    endproperty
    property p_chk_answer;
        chkValid && ce |=> chkDone;
    endproperty
    property p_chk_quiet;
        !chkValid && ce |=> !chkDone && !chkFault;
    endproperty
    property p_fault_typed;
        chkDone |-> $countones({faultInstr, faultLoad, faultStore}) == chkFault;
    endproperty
    property p_fetch_kind;
        chkValid && ce && chkType == 2'h0 |=> !faultLoad && !faultStore;
    endproperty
    property p_csr_answer;
        csrValid && ce |=> csrDone;
    endproperty
    property p_priv_refused;
        csrValid && ce && csrPriv != 2'h3 |=> csrIllegal && csrRdata == 64'h0;
    endproperty
    property p_odd_wide;
        csrValid && ce && machineWidth64 && !csrSel && csrNum[0] |=> csrIllegal;
    endproperty
    property p_narrow_ok;
        csrValid && ce && csrPriv == 2'h3 && !machineWidth64 && !csrSel && csrNum < 6'h10
            |=> !csrIllegal;
    endproperty
    property p_cfg_reserved;
        csrValid && ce && !csrSel |=> (csrRdata & 64'h6060606060606060) == 64'h0;
    endproperty
    property p_addr_width;
        csrValid && ce && csrSel |=> (csrRdata >> (PHYS_W - 2)) == 64'h0;
    endproperty
    a_rw_kept: assert property (p_rw_kept) else $error("write-only combination kept");
    a_chk_answer: assert property (p_chk_answer) else $error("no check result");
    a_chk_quiet: assert property (p_chk_quiet) else $error("result without access");
    a_fault_typed: assert property (p_fault_typed) else $error("fault kind mismatch");
    a_fetch_kind: assert property (p_fetch_kind) else $error("fetch gave data fault");
    a_csr_answer: assert property (p_csr_answer) else $error("register access unanswered");
    a_priv_refused: assert property (p_priv_refused) else $error("low privilege served");
    a_odd_wide: assert property (p_odd_wide) else $error("odd wide config served");
    a_narrow_ok: assert property (p_narrow_ok) else $error("narrow config refused");
    a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved bits set");
    a_addr_width: assert property (p_addr_width) else $error("address too wide");
endmodule : prag_asserts

bind physical_region_access_guard prag_asserts #(.PHYS_W(PHYS_W)) u_asserts (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .machineWidth64(machineWidth64),
    .csrValid(csrValid), .csrWrite(csrWrite), .csrSel(csrSel), .csrNum(csrNum),
    .csrPriv(csrPriv), .csrWdata(csrWdata), .csrDone(csrDone), .csrIllegal(csrIllegal),
    .csrRdata(csrRdata), .chkValid(chkValid), .chkType(chkType), .chkDone(chkDone),
    .chkFault(chkFault), .faultInstr(faultInstr), .faultLoad(faultLoad),
    .faultStore(faultStore)
);

//--- testbench/prag_hart_model.sv
`timescale 1ns/1ns
module prag_hart_model (
    input wire logic clk_sys,
    output logic chkValid,
    output logic [55:0] chkAddr,
    output logic [1:0] chkSize,
    output logic [1:0] chkType,
    output logic [1:0] chkPriv,
    output logic chkPageWalk,
    output logic modifyPrivilege,
    output logic [1:0] previousPrivilege
);
    initial begin
        chkValid = 1'b0;
        chkAddr = 56'h0;
        chkSize = 2'h0;
        chkType = 2'h0;
        chkPriv = 2'h3;
        chkPageWalk = 1'b0;
        modifyPrivilege = 1'b0;
        previousPrivilege = 2'h0;
    end
    // idle address wanders so a stale value never looks like a request
    always @(posedge clk_sys) begin
        if (!chkValid) begin
            chkAddr <= ~chkAddr;
        end
    end
    // held until the taking edge; keep chains the next access back to back
    task automatic issue(logic [55:0] a, logic [1:0] sz, logic [1:0] ty, logic [1:0] pr,
                         logic pw, logic mp, logic [1:0] pp, bit keep);
        if (!chkValid) begin
            @(posedge clk_sys);
            #1;
        end
        chkValid = 1'b1;
        chkAddr = a;
        chkSize = sz;
        chkType = ty;
        chkPriv = pr;
        chkPageWalk = pw;
        modifyPrivilege = mp;
        previousPrivilege = pp;
        @(posedge clk_sys);
        #1;
        if (!keep) begin
            chkValid = 1'b0;
        end
    endtask : issue
endmodule : prag_hart_model

//--- testbench/physical_region_access_guard_tb_top.sv
`timescale 1ns/1ns
module physical_region_access_guard_tb_top;
    logic clk_sys, rstn, ce, machineWidth64, csrValid, csrWrite, csrSel;
    logic [5:0] csrNum;
    logic [1:0] csrPriv;
    logic [63:0] csrWdata, csrRdata, d;
    logic csrDone, csrIllegal, chkValid, chkPageWalk, modifyPrivilege, chkDone, chkFault;
    logic faultInstr, faultLoad, faultStore;
    logic [55:0] chkAddr;
    logic [1:0] chkSize, chkType, chkPriv, previousPrivilege;
    logic [7:0] cfgM [64];
    logic [31:0] adrM [64];
    int error_cnt = 0;
    int comparisons = 0;
    int seed = 71;
    physical_region_access_guard #(.NUM_ENTRIES(16), .GRAIN(0), .PHYS_W(34)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .machineWidth64(machineWidth64),
        .csrValid(csrValid), .csrWrite(csrWrite), .csrSel(csrSel), .csrNum(csrNum),
        .csrPriv(csrPriv), .csrWdata(csrWdata), .csrDone(csrDone), .csrIllegal(csrIllegal),
        .csrRdata(csrRdata), .chkValid(chkValid), .chkAddr(chkAddr), .chkSize(chkSize),
        .chkType(chkType), .chkPriv(chkPriv), .chkPageWalk(chkPageWalk),
        .modifyPrivilege(modifyPrivilege), .previousPrivilege(previousPrivilege),
        .chkDone(chkDone), .chkFault(chkFault), .faultInstr(faultInstr),
        .faultLoad(faultLoad), .faultStore(faultStore));
    prag_hart_model hart (
        .clk_sys(clk_sys), .chkValid(chkValid), .chkAddr(chkAddr), .chkSize(chkSize),
        .chkType(chkType), .chkPriv(chkPriv), .chkPageWalk(chkPageWalk),
        .modifyPrivilege(modifyPrivilege), .previousPrivilege(previousPrivilege));
    // ----------------------------------------
    // reference model
    // ----------------------------------------
    function automatic logic exp_fault(longint a, int sz, int ty, int ep);
        longint lo, hi, top, n, rs;
        int t;
        top = a + (longint'(1) << sz) - 1;
        for (int i = 0; i < 16; i++) begin
            n = longint'(adrM[i]);
            t = 0;
            while (n[t]) t++;
            rs = (cfgM[i][4:3] == 2'h2) ? 4 : longint'(8) << t;
            lo = (cfgM[i][4:3] == 2'h1) ? ((i > 0) ? longint'(adrM[i-1]) << 2 : 0)
                : (n << 2) & ~(rs - 1);
            hi = (cfgM[i][4:3] == 2'h1) ? n << 2 : lo + rs;
            if (cfgM[i][4:3] != 2'h0 && lo < hi && a < hi && top >= lo)
                return a < lo || top >= hi
                    || ((ep != 3 || cfgM[i][7]) && !cfgM[i][ty == 0 ? 2 : ty == 1 ? 0 : 1]);
        end
        return ep != 3;
    endfunction : exp_fault
    function automatic logic [63:0] rd(logic sel, int num);
        logic [63:0] v;
        v = 64'h0;
        if (sel) return (num < 16) ? {32'h0, adrM[num]} : 64'h0;
        for (int k = 0; k < 8; k++) if (k < 4 || machineWidth64) v[8*k +: 8] = cfgM[4*num+k];
        return v;
    endfunction : rd
    task automatic cmp(logic [71:0] seen, logic [71:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : cmp
    task automatic csr(logic wr, logic sel, logic [5:0] num, logic [1:0] pr, logic [63:0] wd,
                       bit keep);
        logic ill;
        logic [63:0] ev;
        if (!csrValid) begin
            @(posedge clk_sys);
            #1;
        end
        ill = pr != 2'h3 || (!sel && (num > 15 || (machineWidth64 && num[0])));
        ev = ill ? 64'h0 : rd(sel, num);
        csrValid = 1'b1;
        csrWrite = wr;
        csrSel = sel;
        csrNum = num;
        csrPriv = pr;
        csrWdata = wd;
        @(posedge clk_sys);
        #1;
        if (wr && !ill && sel && num < 16 && !cfgM[num][7]
            && !(cfgM[num+1][7] && cfgM[num+1][4:3] == 2'h1)) adrM[num] = wd[31:0];
        for (int k = 0; k < 8; k++)
            if (wr && !ill && !sel && (k < 4 || machineWidth64) && 4*num+k < 16
                && !cfgM[4*num+k][7])
                cfgM[4*num+k] = wd[8*k +: 8] & 8'h9f & ~{6'h0, !wd[8*k], 1'b0};
        cmp({csrDone, csrIllegal, csrRdata}, {1'b1, ill, ev});
        if (!keep) csrValid = 1'b0;
    endtask : csr
    task automatic chk(logic [55:0] a, logic [1:0] sz, logic [1:0] ty, logic [1:0] pr,
                       logic pw, logic mp, logic [1:0] pp, bit keep);
        logic f;
        f = exp_fault(longint'(a), sz, ty, pw ? 1 : (ty != 0 && mp) ? pp : pr);
        hart.issue(a, sz, ty, pr, pw, mp, pp, keep);
        cmp({chkDone, chkFault, faultInstr, faultLoad, faultStore},
            {1'b1, f, f && ty == 0, f && ty == 1, f && ty >= 2});
    endtask : chk
    task automatic do_reset();
        rstn = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        foreach (cfgM[i]) cfgM[i] = 8'h00;
        foreach (adrM[i]) adrM[i] = 32'h0;
    endtask : do_reset
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        {machineWidth64, csrValid, csrWrite, csrSel, csrNum, csrPriv, csrWdata} = '0;
        ce = 1'b1;
        do_reset();
        csr(1'b0, 1'b0, 6'h00, 2'h3, 64'h0, 1'b0);
        csr(1'b1, 1'b1, 6'h00, 2'h3, '1, 1'b1);
        csr(1'b0, 1'b1, 6'h00, 2'h3, 64'h0, 1'b1);
        csr(1'b1, 1'b0, 6'h00, 2'h3, 64'h02, 1'b1);
        csr(1'b0, 1'b0, 6'h00, 2'h3, 64'h0, 1'b0);
        for (int i = 0; i < 8; i++) chk(56'h40, 2'h2, i[1:0], {i[2], 1'b1}, 1'b0, i[0], 2'h1,
                                        1'b1);
        chk(56'h40, 2'h0, 2'h1, 2'h3, 1'b1, 1'b0, 2'h3, 1'b0);
        // a write held while frozen must neither answer nor land
        ce = 1'b0;
        {csrValid, csrWrite, csrSel, csrNum, csrPriv, csrWdata} = {3'h7, 6'h02, 2'h3, 64'h55};
        repeat (3) @(posedge clk_sys);
        #1;
        cmp({csrDone, csrRdata}, 65'h0);
        csrValid = 1'b0;
        ce = 1'b1;
        csr(1'b0, 1'b1, 6'h02, 2'h3, 64'h0, 1'b0);
        machineWidth64 = 1'b1;
        for (int i = 0; i < 4; i++) csr(1'b0, 1'b0, 6'(i + 1), 2'(i), 64'h0, 1'b0);
        csr(1'b0, 1'b0, 6'h10, 2'h3, 64'h0, 1'b0);
        machineWidth64 = 1'b0;
        csr(1'b1, 1'b1, 6'h00, 2'h3, 64'h10, 1'b1);
        csr(1'b1, 1'b1, 6'h01, 2'h3, 64'h20, 1'b1);
        csr(1'b1, 1'b0, 6'h00, 2'h3, 64'h8c00, 1'b1);
        csr(1'b1, 1'b1, 6'h00, 2'h3, 64'h0, 1'b0);
        for (int i = 0; i < 8; i++) chk(56'(i * 28), 2'h2, i[1:0], 2'h3, 1'b0, 1'b0, 2'h0,
                                        1'b1);
        chk(56'h0, 2'h0, 2'h1, 2'h1, 1'b0, 1'b0, 2'h0, 1'b0);
        do_reset();
        csr(1'b0, 1'b0, 6'h00, 2'h3, 64'h0, 1'b0);
        for (int r = 0; r < 40; r++) begin
            for (int j = 0; j < 5; j++) begin
                machineWidth64 = 1'($random(seed));
                csrSel = 1'($random(seed));
                d = {$random(seed), $random(seed)} & (csrSel ? 64'h1ff
                    : (r == 30 ? 64'h9f9f9f9f9f9f9f9f : 64'h1f1f1f1f1f1f1f1f));
                csr(1'($random(seed)), csrSel, 6'($random(seed)) & 6'h1f,
                    (($random(seed) & 7) == 0) ? 2'h1 : 2'h3, d, j < 4);
            end
            for (int j = 0; j < 6; j++)
                chk(56'($random(seed)) & 56'h7ff, 2'($random(seed)), 2'($random(seed)),
                    2'($random(seed)), ($random(seed) & 7) == 0, 1'($random(seed)),
                    2'($random(seed)), j < 5);
        end
        results();
    end
endmodule : physical_region_access_guard_tb_top
